// ===== src/ttp_channel.sv
// One timer channel: configuration, shadowing, counter and pin
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module ttp_channel
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire ttp_pkg::ttp_cmd_s cmd_in,
    output logic running_out,
    output logic [15:0] rdata_out,
    output logic irq_set_out,
    output logic err_set_out,
    output logic pin_o_out,
    output logic pin_oe_n_out
);
    typedef enum logic [1:0] {
        TTP_ST_IDLE = 2'b00,
        TTP_ST_WAIT = 2'b01,
        TTP_ST_HIGH = 2'b10,
        TTP_ST_LOW = 2'b11
    } ttp_state_e;

    ttp_pkg::ttp_cfg_s cfg_reg;
    logic [15:0] prdh_sh_reg, prdl_sh_reg, wh_sh_reg;
    logic [31:0] prd_reg, wid_reg, cnt_reg;
    logic bad_reg;
    logic [1:0] dly_reg, err_dly_reg;
    ttp_state_e st_reg;
    logic pin_act_reg;

    wire logic wr = cmd_in.wr;
    wire logic wr_wl = wr && cmd_in.ofs == ttp_pkg::TTP_WL_OFS;
    wire logic [31:0] new_wid = {wh_sh_reg, cmd_in.data};
    wire logic [31:0] new_prd = {prdh_sh_reg, prdl_sh_reg};
    // Validity check on the committed values
    wire logic new_bad = new_wid == 32'h0 || new_prd <= new_wid;
    wire logic pulse = cfg_reg.mode == ttp_pkg::TTP_MODE_PULSE;
    wire logic at_top = cnt_reg == ttp_pkg::TTP_TOP;
    wire logic [31:0] ld_wid = ttp_pkg::TTP_ONES - wid_reg;
    wire logic [31:0] ld_low = ttp_pkg::TTP_ONES - (prd_reg - wid_reg);

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            cfg_reg <= '0;
            prdh_sh_reg <= ttp_pkg::TTP_RESET_VAL;
            prdl_sh_reg <= ttp_pkg::TTP_RESET_VAL;
            wh_sh_reg <= ttp_pkg::TTP_RESET_VAL;
            prd_reg <= 32'h0;
            wid_reg <= 32'h0;
            bad_reg <= 1'b1;
        end
        else if (wr)
        begin
            case (cmd_in.ofs)
                ttp_pkg::TTP_CFG_OFS: cfg_reg <= cmd_in.data[4:0];
                ttp_pkg::TTP_PRDH_OFS: prdh_sh_reg <= cmd_in.data;
                ttp_pkg::TTP_PRDL_OFS: prdl_sh_reg <= cmd_in.data;
                ttp_pkg::TTP_WH_OFS: wh_sh_reg <= cmd_in.data;
                ttp_pkg::TTP_WL_OFS:
                begin
                    prd_reg <= new_prd;
                    wid_reg <= new_wid;
                    bad_reg <= new_bad;
                end
                default:
                begin
                end
            endcase
        end
    end

    // Error flags two cycles after a failing width low write
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
            err_dly_reg <= 2'h0;
        else if (wr_wl && new_bad)
            // Pulse one edge early so the status flag lands on the second
            err_dly_reg <= ttp_pkg::TTP_ERR_DELAY - 2'h1;
        else if (err_dly_reg != 2'h0)
            err_dly_reg <= err_dly_reg - 2'h1;
    end

    // ****************************************************************
    // Counter state machine
    // ****************************************************************
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            st_reg <= TTP_ST_IDLE;
            cnt_reg <= 32'h0;
            dly_reg <= 2'h0;
            pin_act_reg <= 1'b0;
            irq_set_out <= 1'b0;
            err_set_out <= 1'b0;
        end
        else
        begin
            irq_set_out <= 1'b0;
            err_set_out <= 1'b0;
            if (err_dly_reg == 2'h1)
            begin
                err_set_out <= 1'b1;
                irq_set_out <= cfg_reg.interrupt_enable_bit;
            end
            if (cmd_in.dis_set)
            begin
                st_reg <= TTP_ST_IDLE;
                pin_act_reg <= 1'b0;
            end
            else
            begin
                case (st_reg)
                    TTP_ST_IDLE:
                        if (cmd_in.en_set)
                        begin
                            st_reg <= TTP_ST_WAIT;
                            dly_reg <= ttp_pkg::TTP_START_DELAY - 2'h1;
                        end
                    TTP_ST_WAIT:
                        // Bad values or other modes: enabled but idle
                        if (dly_reg != 2'h0)
                            dly_reg <= dly_reg - 2'h1;
                        else if (pulse && !bad_reg)
                        begin
                            cnt_reg <= ld_wid;
                            st_reg <= TTP_ST_HIGH;
                            pin_act_reg <= 1'b1;
                        end
                    TTP_ST_HIGH:
                        if (!at_top)
                            cnt_reg <= cnt_reg + 32'h1;
                        else if (!cfg_reg.period_cont)
                        begin
                            st_reg <= TTP_ST_IDLE;
                            pin_act_reg <= 1'b0;
                            irq_set_out <= cfg_reg.interrupt_enable_bit;
                        end
                        else
                        begin
                            cnt_reg <= ld_low;
                            st_reg <= TTP_ST_LOW;
                            pin_act_reg <= 1'b0;
                        end
                    TTP_ST_LOW:
                        if (!at_top)
                            cnt_reg <= cnt_reg + 32'h1;
                        else
                        begin
                            cnt_reg <= ld_wid;
                            st_reg <= TTP_ST_HIGH;
                            pin_act_reg <= 1'b1;
                            irq_set_out <= cfg_reg.interrupt_enable_bit;
                        end
                    default: st_reg <= TTP_ST_IDLE;
                endcase
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            pin_o_out <= 1'b0;
            pin_oe_n_out <= 1'b1;
            running_out <= 1'b0;
        end
        else
        begin
            // Pin low unless running; level set by polarity
            pin_o_out <= (st_reg == TTP_ST_HIGH || st_reg == TTP_ST_LOW)
                && (pin_act_reg == cfg_reg.pol_high);
            pin_oe_n_out <= !pulse;
            running_out <= st_reg != TTP_ST_IDLE
                && !(cmd_in.dis_set);
        end
    end

    // Counter reads are not coherent; hi/lo read live
    always_comb
    begin
        case (cmd_in.ofs)
            ttp_pkg::TTP_CFG_OFS: rdata_out = {11'h000, cfg_reg};
            ttp_pkg::TTP_CNTH_OFS: rdata_out = cnt_reg[31:16];
            ttp_pkg::TTP_CNTL_OFS: rdata_out = cnt_reg[15:0];
            ttp_pkg::TTP_PRDH_OFS: rdata_out = prd_reg[31:16];
            ttp_pkg::TTP_PRDL_OFS: rdata_out = prd_reg[15:0];
            ttp_pkg::TTP_WH_OFS: rdata_out = wid_reg[31:16];
            ttp_pkg::TTP_WL_OFS: rdata_out = wid_reg[15:0];
            default: rdata_out = 16'h0000;
        endcase
    end

    start_delay_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        st_reg == TTP_ST_IDLE && cmd_in.en_set && !cmd_in.dis_set
        |=> st_reg == TTP_ST_WAIT [*3])
        else $error("start delay wrong");
    err_delay_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        wr_wl && new_bad |-> ##2 err_set_out)
        else $error("error flag timing wrong");
    dis_stop_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        cmd_in.dis_set |=> st_reg == TTP_ST_IDLE)
        else $error("disable did not stop");
    pin_idle_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        st_reg == TTP_ST_IDLE && $past(st_reg) == TTP_ST_IDLE
        |=> !pin_o_out)
        else $error("pin not low while idle");
    hold_cnt_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        st_reg == TTP_ST_IDLE && !cmd_in.en_set |=> $stable(cnt_reg))
        else $error("counter changed while idle");
    irq_gate_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !cfg_reg.interrupt_enable_bit && !$past(cfg_reg.interrupt_enable_bit) |-> !irq_set_out)
        else $error("latch set with interrupts off");
    reload_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        st_reg == TTP_ST_HIGH && at_top && cfg_reg.period_cont
        && !cmd_in.dis_set |=> cnt_reg == $past(ld_low))
        else $error("reload value wrong");
    oe_mode_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        pulse && $past(pulse) |-> !pin_oe_n_out)
        else $error("pin not driven in pulse mode");
endmodule

// ===== src/ttp_pkg.sv
// Package: register map, fields and types of the triple timer block
// ****************************************************************
// Summary of operation
// - Three timers, 32-bit counters, three modes
// - Pin drives in pulse mode, input otherwise
// - Internal counting on the peripheral clock
// - Bits 8/10/12 enable, 9/11/13 disable, both disables
// - Enabled reads both bits one; count after three
// - Disable write stops timer at once
// - Latch bits 0-2, overflow 4-6 sticky W1C, outputs
// - One write clears flags and enables/disables together
// - Interrupt enable clear means latch never set
// - Period and width halves stay coherent
// - Disabled counter holds; reinit on enable; read-only
// - Mode 01 selects pulse output, pin driven
// - Period and width high shadowed until width low
// - Width low write checks zero, below, equal
// - Failed check sets overflow and latch two cycles later
// - All timer registers reset to zero
// - Load ones minus width, reload ones minus low part
// - Pin low while disabled, polarity while running
// - Continuous bit repeats waveform, clear gives one pulse
// - Deassert when width expires, assert at period/start
// - Polarity bit set means asserted high
// - Continuous mode raises interrupt every period end
// - Single pulse uses width, latches, stops itself
// ****************************************************************
package ttp_pkg;
    localparam int TTP_NUM = 3;
    localparam logic [7:0] TTP_GSR_ADDR = 8'h00;
    // Per timer block: base 0x10 + 0x20 * index
    localparam logic [7:0] TTP_TMR_BASE = 8'h10;
    localparam logic [7:0] TTP_TMR_STRIDE = 8'h20;
    localparam logic [4:0] TTP_CFG_OFS = 5'h00;
    localparam logic [4:0] TTP_CNTH_OFS = 5'h04;
    localparam logic [4:0] TTP_CNTL_OFS = 5'h08;
    localparam logic [4:0] TTP_PRDH_OFS = 5'h0C;
    localparam logic [4:0] TTP_PRDL_OFS = 5'h10;
    localparam logic [4:0] TTP_WH_OFS = 5'h14;
    localparam logic [4:0] TTP_WL_OFS = 5'h18;
    localparam int TTP_IL_POS = 0;
    localparam int TTP_OVF_POS = 4;
    localparam int TTP_EN_POS = 8;
    localparam int TTP_CFG_MODE_LSB = 0;
    localparam int TTP_CFG_POL_POS = 2;
    localparam int TTP_CFG_PER_POS = 3;
    localparam int TTP_CFG_IRQ_POS = 4;
    localparam logic [15:0] TTP_RESET_VAL = 16'h0000;
    localparam logic [1:0] TTP_START_DELAY = 2'h3;
    localparam logic [1:0] TTP_ERR_DELAY = 2'h2;
    localparam logic [31:0] TTP_ONES = 32'hFFFFFFFF;
    localparam logic [31:0] TTP_TOP = 32'hFFFFFFFE;
    localparam logic [1:0] TTP_RESP_OK = 2'h0;
    localparam logic [1:0] TTP_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        TTP_MODE_OFF = 2'b00,
        TTP_MODE_PULSE = 2'b01,
        TTP_MODE_WIDTH = 2'b10,
        TTP_MODE_EXT = 2'b11
    } ttp_mode_e;

    typedef struct packed {
        logic interrupt_enable_bit;
        logic period_cont;
        logic pol_high;
        ttp_mode_e mode;
    } ttp_cfg_s;

    typedef struct packed {
        logic wr;
        logic [4:0] ofs;
        logic [15:0] data;
        logic en_set;
        logic dis_set;
    } ttp_cmd_s;
endpackage

// ===== src/ttp_top.sv
// Top: AXI4-Lite slave, global status/control, three timer channels
`timescale 1ns/1ns
module ttp_top
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [2:0] timer_pin_o_out,
    output logic [2:0] timer_pin_oe_n_out,
    output logic [2:0] interrupt_latch_out,
    output logic [2:0] overflow_error_flag_out,
    output logic [2:0] timer_irq_out
);
    localparam int N = ttp_pkg::TTP_NUM;

    logic aw_full_reg, w_full_reg;
    logic [7:0] awaddr_reg;
    logic [15:0] wdata_reg;
    logic wstrb_ok_reg;
    logic [2:0] il_reg, ovf_reg;
    logic [N-1:0] run_w, irq_set_w, err_set_w, pin_w, oe_w;
    logic [15:0] ch_rd_w [N];

    // ****************************************************************
    // Write channel capture, either order
    // ****************************************************************
    wire logic do_wr = aw_full_reg && w_full_reg && !s_axi_bvalid_out;
    wire logic gsr_wr = do_wr && wstrb_ok_reg
        && awaddr_reg == ttp_pkg::TTP_GSR_ADDR;
    wire logic [7:0] wr_rel = awaddr_reg - ttp_pkg::TTP_TMR_BASE;
    wire logic [7:0] rd_rel = s_axi_araddr_in - ttp_pkg::TTP_TMR_BASE;
    wire logic wr_blk = awaddr_reg >= ttp_pkg::TTP_TMR_BASE
        && wr_rel < 8'h60 && wr_rel[4:0] <= ttp_pkg::TTP_WL_OFS
        && wr_rel[1:0] == 2'b00;
    wire logic rd_blk = s_axi_araddr_in >= ttp_pkg::TTP_TMR_BASE
        && rd_rel < 8'h60 && rd_rel[4:0] <= ttp_pkg::TTP_WL_OFS
        && rd_rel[1:0] == 2'b00;
    wire logic [1:0] wr_ch = wr_rel[6:5];
    wire logic [1:0] rd_ch = rd_rel[6:5];
    wire logic wr_ok = awaddr_reg == ttp_pkg::TTP_GSR_ADDR || wr_blk;
    wire logic rd_ok = s_axi_araddr_in == ttp_pkg::TTP_GSR_ADDR || rd_blk;
    // Both bits of a pair: disable wins
    wire logic [2:0] en_w = {wdata_reg[12], wdata_reg[10], wdata_reg[8]};
    wire logic [2:0] dis_w = {wdata_reg[13], wdata_reg[11], wdata_reg[9]};
    wire logic [15:0] gsr_rd = {2'b00, run_w[2], run_w[2], run_w[1],
        run_w[1], run_w[0], run_w[0], 1'b0, ovf_reg, 1'b0, il_reg};

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 16'h0000;
            wstrb_ok_reg <= 1'b0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= ttp_pkg::TTP_RESP_OK;
        end
        else
        begin
            if (s_axi_awvalid_in && s_axi_awready_out)
            begin
                aw_full_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out)
            begin
                w_full_reg <= 1'b1;
                wdata_reg <= s_axi_wdata_in[15:0];
                // 16-bit registers need both low byte lanes
                wstrb_ok_reg <= &s_axi_wstrb_in[1:0];
            end
            if (do_wr)
            begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= wr_ok ? ttp_pkg::TTP_RESP_OK
                    : ttp_pkg::TTP_RESP_SLVERR;
            end
            else if (s_axi_bready_in)
                s_axi_bvalid_out <= 1'b0;
        end
    end

    assign s_axi_awready_out = !aw_full_reg && !s_axi_bvalid_out;
    assign s_axi_wready_out = !w_full_reg && !s_axi_bvalid_out;

    // ****************************************************************
    // Read channel, one cycle to data
    // ****************************************************************
    // Reads wait while a write owns the shared channel offset
    assign s_axi_arready_out = !s_axi_rvalid_out && !do_wr;

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h00000000;
            s_axi_rresp_out <= ttp_pkg::TTP_RESP_OK;
        end
        else if (s_axi_arvalid_in && s_axi_arready_out)
        begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out <= rd_ok ? ttp_pkg::TTP_RESP_OK
                : ttp_pkg::TTP_RESP_SLVERR;
            if (s_axi_araddr_in == ttp_pkg::TTP_GSR_ADDR)
                s_axi_rdata_out <= {16'h0000, gsr_rd};
            else if (rd_blk)
                s_axi_rdata_out <= {16'h0000, ch_rd_w[rd_ch]};
            else
                s_axi_rdata_out <= 32'h00000000;
        end
        else if (s_axi_rready_in)
            s_axi_rvalid_out <= 1'b0;
    end

    // ****************************************************************
    // Sticky flags: hardware set beats software clear
    // ****************************************************************
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            il_reg <= 3'h0;
            ovf_reg <= 3'h0;
        end
        else
        begin
            il_reg <= (il_reg & ~(gsr_wr ? wdata_reg[2:0] : 3'h0))
                | irq_set_w;
            ovf_reg <= (ovf_reg & ~(gsr_wr ? wdata_reg[6:4] : 3'h0))
                | err_set_w;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            interrupt_latch_out <= 3'h0;
            overflow_error_flag_out <= 3'h0;
            timer_irq_out <= 3'h0;
        end
        else
        begin
            interrupt_latch_out <= il_reg;
            overflow_error_flag_out <= ovf_reg;
            timer_irq_out <= il_reg;
        end
    end

    assign timer_pin_o_out = pin_w;
    assign timer_pin_oe_n_out = oe_w;

    // ****************************************************************
    // Timer channels
    // ****************************************************************
    for (genvar i = 0; i < N; i++)
    begin : g_ch
        ttp_pkg::ttp_cmd_s cmd_w;
        assign cmd_w.wr = do_wr && wr_blk && wstrb_ok_reg
            && wr_ch == 2'(i) && wr_rel[4:0] != ttp_pkg::TTP_CNTH_OFS
            && wr_rel[4:0] != ttp_pkg::TTP_CNTL_OFS;
        assign cmd_w.ofs = do_wr ? wr_rel[4:0] : rd_rel[4:0];
        assign cmd_w.data = wdata_reg;
        assign cmd_w.en_set = gsr_wr && en_w[i] && !dis_w[i];
        assign cmd_w.dis_set = gsr_wr && dis_w[i];
        ttp_channel u_ch
        (
            .clock_in(clock_in),
            .rst_n_in(rst_n_in),
            .cmd_in(cmd_w),
            .running_out(run_w[i]),
            .rdata_out(ch_rd_w[i]),
            .irq_set_out(irq_set_w[i]),
            .err_set_out(err_set_w[i]),
            .pin_o_out(pin_w[i]),
            .pin_oe_n_out(oe_w[i])
        );
    end

    latch_out_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        irq_set_w[0] |=> ##1 interrupt_latch_out[0] && timer_irq_out[0])
        else $error("latch output missing");
    set_wins_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        err_set_w[1] |=> ovf_reg[1])
        else $error("overflow set lost");
endmodule

// ===== testbench/tb_top.sv
// Self-checking testbench for the triple timer block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
    $display("ERROR %0s exp %0h got %0h", nm, ex, got); num_errors++; end end
module tb_top;
    logic clock_in, rst_n_in, awvalid, wvalid, arvalid;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, rs;
    logic [2:0] pin_o, pin_oe_n, latch, ovf, irq, pin_lvl;
    logic [15:0] rv, c0;
    logic [7:0] ra[5];
    logic [15:0] rw[5], rx[5];
    logic [1:0] rr[5];
    int num_errors, n_tests, cyc;
    localparam logic [7:0] gsr_a = ttp_pkg::TTP_GSR_ADDR;
    ttp_top ttp_top_i(.clock_in(clock_in), .rst_n_in(rst_n_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(1'b1),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(1'b1), .timer_pin_o_out(pin_o),
        .timer_pin_oe_n_out(pin_oe_n), .interrupt_latch_out(latch),
        .overflow_error_flag_out(ovf), .timer_irq_out(irq));
    ttp_pin_model ttp_pin_model_i(.clock_in(clock_in), .pin_o_in(pin_o),
        .pin_oe_n_in(pin_oe_n), .level_out(pin_lvl));
    // ****
    // Clock, timeout, verdict
    // ****
    initial
    begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end
    task print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clock_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 10000)
        begin
            num_errors++;
            print_verdict;
        end
    end
    // ****
    // Bus and pin tasks
    // ****
    function automatic logic [7:0] ta(input int i, input logic [4:0] o);
        ta = ttp_pkg::TTP_TMR_BASE + ttp_pkg::TTP_TMR_STRIDE * 8'(i) + 8'(o);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        forever
        begin
            @(posedge clock_in);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                rs = bresp;
                break;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        forever
        begin
            @(posedge clock_in);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                rv = rdata[15:0];
                rs = rresp;
                break;
            end
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] ex);
        rd(a);
        `CHK("rdata", ex, rv)
    endtask
    // Waits for a fresh active phase, then times active and idle spans
    task automatic meas(input int i, input logic lvl, input int hi, lo);
        int n, m;
        n = 0;
        m = 0;
        while (pin_lvl[i] !== ~lvl) @(posedge clock_in);
        while (pin_lvl[i] !== lvl) @(posedge clock_in);
        while (pin_lvl[i] === lvl)
        begin
            n++;
            @(posedge clock_in);
        end
        while (pin_lvl[i] !== lvl && m < 50)
        begin
            m++;
            @(posedge clock_in);
        end
        `CHK("active span", hi, n)
        `CHK("idle span", lo, m)
    endtask
    task automatic bad(input int i, input logic [15:0] p, w, g);
        wr(ta(i, ttp_pkg::TTP_PRDL_OFS), p);
        wr(ta(i, ttp_pkg::TTP_WL_OFS), w);
        repeat (4) @(posedge clock_in);
        rc(gsr_a, g);
        `CHK("overflow out", g[6:4], ovf)
        `CHK("irq out", g[2:0], irq)
        rc(ta(i, ttp_pkg::TTP_CNTL_OFS), 16'h0000);
        wr(gsr_a, g);
        rc(gsr_a, 16'h0000);
        $display("test bad values done");
    endtask
    // ****
    // Main sequence
    // ****
    initial
    begin
        {rst_n_in, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
        {num_errors, n_tests, cyc} = '0;
        ra = '{ta(0, 5'h00), ta(1, 5'h08), ta(2, 5'h04), 8'h04, 8'h70};
        rw = '{16'h0019, 16'h1234, 16'hFFFF, 16'h0001, 16'h0001};
        rx = '{16'h0019, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
        rr = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h2};
        repeat (20) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
        rc(gsr_a, 16'h0000);
        for (int i = 0; i < 3; i++)
            rc(ta(i, ttp_pkg::TTP_CFG_OFS), 16'h0000);
        `CHK("oe_n", 3'h7, pin_oe_n)
        for (int k = 0; k < 5; k++)
        begin
            wr(ra[k], rw[k]);
            `CHK("bresp", rr[k], rs)
            rd(ra[k]);
            `CHK("rresp", rr[k], rs)
            if (rr[k] == 2'h0)
                `CHK("rdata", rx[k], rv)
            $display("test row %0d done", k);
        end
        `CHK("oe_n", 3'h6, pin_oe_n)
        // Configure before enabling, never while running
        wr(ta(2, ttp_pkg::TTP_CFG_OFS), 16'h0019);
        wr(ta(1, ttp_pkg::TTP_CFG_OFS), 16'h0009);
        bad(2, 16'h0005, 16'h0000, 16'h0044);
        bad(2, 16'h0002, 16'h0003, 16'h0044);
        bad(2, 16'h0004, 16'h0004, 16'h0044);
        bad(1, 16'h0005, 16'h0000, 16'h0020);
        for (int p = 0; p < 2; p++)
        begin
            wr(ta(0, ttp_pkg::TTP_CFG_OFS), p ? 16'h001D : 16'h0019);
            wr(ta(0, ttp_pkg::TTP_PRDL_OFS), 16'h0005);
            wr(ta(0, ttp_pkg::TTP_WL_OFS), 16'h0002);
            wr(gsr_a, 16'h0100);
            rc(gsr_a, 16'h0300);
            meas(0, p[0], 2, 3);
            repeat (3) @(posedge clock_in);
            `CHK("latch out", 1'b1, latch[0])
            wr(gsr_a, 16'h0200);
            repeat (2) @(posedge clock_in);
            `CHK("pin level", 1'b0, pin_lvl[0])
            wr(gsr_a, 16'h0011);
            rc(gsr_a, 16'h0000);
            $display("test continuous %0d done", p);
        end
        rd(ta(0, ttp_pkg::TTP_CNTL_OFS));
        c0 = rv;
        repeat (5) @(posedge clock_in);
        rc(ta(0, ttp_pkg::TTP_CNTL_OFS), c0);
        wr(ta(0, ttp_pkg::TTP_PRDL_OFS), 16'h0007);
        rc(ta(0, ttp_pkg::TTP_PRDL_OFS), 16'h0005);
        wr(ta(0, ttp_pkg::TTP_WL_OFS), 16'h0002);
        rc(ta(0, ttp_pkg::TTP_PRDL_OFS), 16'h0007);
        wr(ta(1, ttp_pkg::TTP_CFG_OFS), 16'h0015);
        wr(ta(1, ttp_pkg::TTP_PRDL_OFS), 16'h0009);
        wr(ta(1, ttp_pkg::TTP_WL_OFS), 16'h0003);
        wr(gsr_a, 16'h0400);
        meas(1, 1'b1, 3, 50);
        rc(gsr_a, 16'h0002);
        `CHK("irq out", 1'b1, irq[1])
        wr(gsr_a, 16'h0402);
        rc(gsr_a, 16'h0C00);
        meas(1, 1'b1, 3, 50);
        rc(gsr_a, 16'h0002);
        $display("test single pulse done");
        wr(gsr_a, 16'h0302);
        rc(gsr_a, 16'h0000);
        $display("test both bits done");
        print_verdict;
    end
endmodule

// ===== testbench/ttp_pin_model.sv
// Far-side model of the three timer pins
`timescale 1ns/1ns
module ttp_pin_model
(
    input wire logic clock_in,
    input wire logic [2:0] pin_o_in,
    input wire logic [2:0] pin_oe_n_in,
    output logic [2:0] level_out
);
    // No pull on the pins: undriven level flips every cycle
    logic [2:0] last_reg = 3'h0;
    always @(posedge clock_in)
        last_reg <= level_out;
    assign level_out = (pin_oe_n_in & ~last_reg) | (~pin_oe_n_in & pin_o_in);
endmodule
